// ===== hw/ics_regs.svh
// Register offsets, field positions, reset values and bit counts of the config slave
`ifndef ICS_REGS_SVH
`define ICS_REGS_SVH

// Fixed seven-bit slave address and the upper five bits of the high-speed master code
`define ICS_SLAVE_ADDR      7'h75
`define ICS_HS_CODE_HI      5'h01

// Register pointer values
`define ICS_REG_CFG         8'h01
`define ICS_REG_LOW_TH      8'h02
`define ICS_REG_UP_TH       8'h03
`define ICS_REG_ILIM        8'h04
`define ICS_REG_STATUS      8'h05
`define ICS_REG_NVM_CTRL    8'hFF
`define ICS_REG_RW_FIRST    8'h01
`define ICS_REG_RW_LAST     8'h04

// Non-volatile access control fields
`define ICS_CTRL_SAVE_BIT   7
`define ICS_CTRL_WP_BIT     6
`define ICS_CTRL_LOCK_BIT   5
`define ICS_CTRL_SEL_BIT    0
`define ICS_CTRL_WMASK      8'h41
`define ICS_CTRL_RESET      8'h00

// Reset values of the volatile registers and factory contents of the stored copy
`define ICS_VOL_RESET       8'h00
`define ICS_NVM_DEF_CFG     8'h01
`define ICS_NVM_DEF_LOW_TH  8'h06
`define ICS_NVM_DEF_UP_TH   8'h00
`define ICS_NVM_DEF_ILIM    8'h00

// Bit counts inside one nine-bit byte frame
`define ICS_BIT_ACK         4'h8
`define ICS_BIT_END         4'h9

`endif

// ===== hw/ics_pkg.sv
// Types shared by the two-wire configuration slave
`default_nettype none
package ics_pkg;

    // Protocol position of the slave engine
    typedef enum logic [2:0]
    {
        S_LOAD,
        S_IDLE,
        S_ADDR,
        S_PTR,
        S_WDATA,
        S_RDATA,
        S_SKIP
    } ics_state_t;

    // Volatile configuration presented to the converter
    typedef struct packed
    {
        logic [7:0] ilim;
        logic [7:0] up_th;
        logic [7:0] low_th;
        logic [7:0] cfg;
    } ics_cfg_t;

    // One sample of both bus lines
    typedef struct packed
    {
        logic scl;
        logic sda;
    } ics_pins_t;

endpackage : ics_pkg
`default_nettype wire

// ===== hw/ics_i2c_cfg_slave.sv
// Two-wire configuration slave with a write-protected non-volatile register copy
//
// Overview of operation
// RULE_01: Slave only, standard to high-speed rates.
// RULE_02: Seven-bit addresses only, no general call.
// RULE_03: Answer only address 111 0101.
// RULE_04: Data fall with clock high starts.
// RULE_05: Data changes only while clock low.
// RULE_06: Acknowledge matched address through ninth clock.
// RULE_07: Eight data bits then one acknowledge.
// RULE_08: Data rise with clock high stops.
// RULE_09: Unmapped register reads return zero.
// RULE_10: Master code switches speed, never acknowledged.
// RULE_11: Repeated start keeps speed, stop ends it.
// RULE_12: Master chains high-speed transfers by restarts.
// RULE_13: Address, pointer, data; each byte acknowledged.
// RULE_14: Commit on falling edge after acknowledge.
// RULE_15: Byte after address is register pointer.
// RULE_16: Map 01h-05h plus control at FFh.
// RULE_17: Load volatile registers from stored copy.
// RULE_18: Writing C0h to FFh saves registers.
// RULE_19: Saved write-protect bit locks storage forever; reset clears the lock.
// RULE_20: Reads allowed always, protection ignored.
// RULE_21: Volatile contents kept while supply holds.
// RULE_22: Master sends stop after pull-up power-up.
// RULE_23: Read via pointer write, restart, read.
// RULE_24: Unmapped writes acknowledged and discarded.
`include "ics_regs.svh"
`default_nettype none
module ics_i2c_cfg_slave
(
    input  wire logic              CLK_I,
    input  wire logic              SRST_I,
    input  wire logic              SCL_I,
    input  wire logic              SDA_I,
    output var  logic              SDA_O,
    output var  logic              SDA_OE_O,
    input  wire logic [7:0]        STATUS_I,
    output wire ics_pkg::ics_cfg_t CFG_O,
    output var  logic              CFG_VALID_O,
    output var  logic              HS_MODE_O,
    output var  logic              WP_LOCKED_O
);
    import ics_pkg::*;

    localparam logic [7:0] NVM_DEF [1:4] = '{`ICS_NVM_DEF_CFG, `ICS_NVM_DEF_LOW_TH,
                                             `ICS_NVM_DEF_UP_TH, `ICS_NVM_DEF_ILIM};

    logic       scl_bit_q;
    ics_pins_t  pin_s1_q;
    ics_pins_t  pin_s2_q;
    ics_pins_t  pin_s3_q;
    ics_pins_t  pin_f_q;
    ics_pins_t  pin_f_d;
    ics_state_t st_q;
    ics_state_t st_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] sh_q;
    logic [7:0] sh_d;
    logic [7:0] tx_q;
    logic [7:0] tx_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic       rw_q;
    logic       rw_d;
    logic       hs_q;
    logic       hs_d;
    logic       oe_q;
    logic       oe_d;
    logic       mack_q;
    logic       mack_d;
    logic       valid_q;
    logic       sda_o_q;
    logic       lock_q;
    logic [7:0] ctrl_q;
    logic [7:0] vol_q [1:4];
    logic [7:0] nvm_q [1:4];

    // Link side: the bit on the data line is captured by the bus clock itself, so it is
    // exact even at the top rate; it stays put until the next rising clock, long after
    // the core has seen that rise through its synchroniser
    always_ff @(posedge SCL_I)
    begin
        scl_bit_q <= SDA_I;
    end

    // RULE_01: three-stage pin filter
    // Lines reset to the idle high level so no false edge follows reset
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            pin_s1_q <= '1;
            pin_s2_q <= '1;
            pin_s3_q <= '1;
            pin_f_q  <= '1;
        end
        else
        begin
            pin_s1_q <= ics_pins_t'({SCL_I, SDA_I});
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_f_q  <= pin_f_d;
        end
    end

    // A level change counts only once the second and third stages agree
    assign pin_f_d.scl = (pin_s2_q.scl == pin_s3_q.scl) ? pin_s3_q.scl : pin_f_q.scl;
    assign pin_f_d.sda = (pin_s2_q.sda == pin_s3_q.sda) ? pin_s3_q.sda : pin_f_q.sda;

    // Bus events; a simultaneous change of both lines is not a start or stop
    wire rise_e  = pin_f_d.scl & ~pin_f_q.scl;
    wire fall_e  = pin_f_q.scl & ~pin_f_d.scl;
    wire clk_hi  = pin_f_q.scl & pin_f_d.scl;
    // RULE_04: start detection
    wire start_e = clk_hi & pin_f_q.sda & ~pin_f_d.sda;
    // RULE_08: stop detection
    wire stop_e  = clk_hi & ~pin_f_q.sda & pin_f_d.sda;

    // RULE_02: ten-bit headers and general call never equal the fixed address
    // RULE_03: fixed address compare
    wire addr_hit = (sh_q[7:1] == `ICS_SLAVE_ADDR);
    // RULE_10: master code recognition
    wire hs_code  = (sh_q[7:3] == `ICS_HS_CODE_HI);

    // RULE_15: pointer decode, low bits pick the entry
    // RULE_16: map of five registers plus control
    wire [2:0] ptr_idx    = ptr_q[2:0];
    wire       ptr_rw_hit = (ptr_q >= `ICS_REG_RW_FIRST) && (ptr_q <= `ICS_REG_RW_LAST);
    wire       ptr_stat   = (ptr_q == `ICS_REG_STATUS);
    wire       ptr_ctrl   = (ptr_q == `ICS_REG_NVM_CTRL);
    wire       sel_nvm    = ctrl_q[`ICS_CTRL_SEL_BIT];
    wire [7:0] ctrl_rd    = ctrl_q | (8'(lock_q) << `ICS_CTRL_LOCK_BIT);

    // RULE_20: read path has no protection term
    wire [7:0] entry_rd = sel_nvm ? nvm_q[ptr_idx] : vol_q[ptr_idx];
    // RULE_09: zero for unmapped pointers
    wire [7:0] rd_byte  = ptr_rw_hit ? entry_rd :
                          ptr_stat   ? STATUS_I :
                          ptr_ctrl   ? ctrl_rd  : 8'h00;

    // RULE_14: commit strobe at the end of the acknowledge clock
    wire wr_e   = fall_e && (cnt_q == `ICS_BIT_END) && (st_q == S_WDATA);
    // RULE_18: save command strobe
    wire save_e = wr_e && ptr_ctrl && sh_q[`ICS_CTRL_SAVE_BIT];

    // Protocol engine; stop wins over start, both abort any byte in flight
    always_comb
    begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        sh_d   = sh_q;
        tx_d   = tx_q;
        ptr_d  = ptr_q;
        rw_d   = rw_q;
        hs_d   = hs_q;
        oe_d   = oe_q;
        mack_d = mack_q;
        if (st_q == S_LOAD)
        begin
            st_d = S_IDLE;
        end
        else if (stop_e)
        begin
            // RULE_08: release the line and wait for a new start
            // RULE_11: stop returns to standard timing
            st_d  = S_IDLE;
            cnt_d = 4'h0;
            oe_d  = 1'b0;
            hs_d  = 1'b0;
        end
        else if (start_e)
        begin
            // RULE_04: new transaction, pointer kept for reads
            // RULE_11: repeated start keeps high-speed mode
            st_d  = S_ADDR;
            cnt_d = 4'h0;
            oe_d  = 1'b0;
        end
        else
        begin
            // RULE_07: eight data bits, the ninth is the acknowledge
            if (rise_e && (cnt_q < `ICS_BIT_END))
            begin
                if (cnt_q < `ICS_BIT_ACK)
                begin
                    sh_d = {sh_q[6:0], scl_bit_q};
                end
                else
                begin
                    mack_d = ~scl_bit_q;
                end
                cnt_d = 4'(cnt_q + 4'h1);
            end
            // RULE_05: every change of the driven line follows a falling clock
            if (fall_e)
            begin
                if (cnt_q == `ICS_BIT_ACK)
                begin
                    case (st_q)
                        S_ADDR:
                        begin
                            // RULE_06: acknowledge a matching address
                            // RULE_10: master code is never acknowledged
                            oe_d = addr_hit;
                            rw_d = sh_q[0];
                            if (hs_code)
                            begin
                                hs_d = 1'b1;
                            end
                        end
                        S_PTR:
                        begin
                            // RULE_13: acknowledge the pointer
                            // RULE_15: second byte becomes the pointer
                            oe_d  = 1'b1;
                            ptr_d = sh_q;
                        end
                        S_WDATA:
                        begin
                            // RULE_24: data is acknowledged even when it is dropped
                            oe_d = 1'b1;
                        end
                        default:
                        begin
                            oe_d = 1'b0;
                        end
                    endcase
                end
                else if (cnt_q == `ICS_BIT_END)
                begin
                    cnt_d = 4'h0;
                    oe_d  = 1'b0;
                    case (st_q)
                        S_ADDR:
                        begin
                            if (addr_hit && rw_q)
                            begin
                                // RULE_23: read direction, drive the pointed byte
                                st_d = S_RDATA;
                                tx_d = rd_byte;
                                oe_d = ~rd_byte[7];
                            end
                            else if (addr_hit)
                            begin
                                st_d = S_PTR;
                            end
                            else
                            begin
                                st_d = S_SKIP;
                            end
                        end
                        S_PTR:
                        begin
                            st_d = S_WDATA;
                        end
                        S_RDATA:
                        begin
                            // RULE_23: master not-acknowledge ends the read
                            if (mack_q)
                            begin
                                tx_d = rd_byte;
                                oe_d = ~rd_byte[7];
                            end
                            else
                            begin
                                st_d = S_SKIP;
                            end
                        end
                        default:
                        begin
                            st_d = st_q;
                        end
                    endcase
                end
                else if ((st_q == S_RDATA) && (cnt_q != 4'h0))
                begin
                    tx_d = {tx_q[6:0], 1'b0};
                    oe_d = ~tx_q[6];
                end
            end
        end
    end

    // Engine state; the load state runs once after every reset
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            st_q   <= S_LOAD;
            cnt_q  <= 4'h0;
            sh_q   <= 8'h00;
            tx_q   <= 8'h00;
            ptr_q  <= 8'h00;
            rw_q   <= 1'b0;
            hs_q   <= 1'b0;
            oe_q   <= 1'b0;
            mack_q <= 1'b0;
        end
        else
        begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            sh_q   <= sh_d;
            tx_q   <= tx_d;
            ptr_q  <= ptr_d;
            rw_q   <= rw_d;
            hs_q   <= hs_d;
            oe_q   <= oe_d;
            mack_q <= mack_d;
        end
    end

    // Control register, lock and output flags; the save bit is a command and never stored
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            ctrl_q  <= `ICS_CTRL_RESET;
            lock_q  <= 1'b0;
            valid_q <= 1'b0;
            sda_o_q <= 1'b0;
        end
        else
        begin
            sda_o_q <= 1'b0;
            // RULE_17: configuration valid only after the load
            if (st_q == S_LOAD)
            begin
                valid_q <= 1'b1;
            end
            // RULE_16: control register write
            if (wr_e && ptr_ctrl)
            begin
                ctrl_q <= sh_q & `ICS_CTRL_WMASK;
            end
            // RULE_19: lock is set by saving with the protect bit and cleared only by reset
            if (save_e && !lock_q && sh_q[`ICS_CTRL_WP_BIT])
            begin
                lock_q <= 1'b1;
            end
        end
    end

    // Per-entry volatile register and stored copy
    for (genvar g = 1; g <= 4; g++)
    begin : g_reg
        wire hit = wr_e && (ptr_q == 8'(g));

        // RULE_21: volatile entries change only by load, write or reset
        // RULE_24: writes to status or unmapped pointers hit no entry
        always_ff @(posedge CLK_I)
        begin
            if (SRST_I)
            begin
                vol_q[g] <= `ICS_VOL_RESET;
            end
            else if (st_q == S_LOAD)
            begin
                // RULE_17: load from the stored copy
                vol_q[g] <= nvm_q[g];
            end
            else if (hit && !sel_nvm)
            begin
                // RULE_14: commit to the volatile entry
                vol_q[g] <= sh_q;
            end
        end

        // Reset stands for a full power-on, so the copy returns to factory contents
        always_ff @(posedge CLK_I)
        begin
            if (SRST_I)
            begin
                nvm_q[g] <= NVM_DEF[g];
            end
            else if (save_e && !lock_q)
            begin
                // RULE_18: save every volatile entry
                nvm_q[g] <= vol_q[g];
            end
            else if (hit && sel_nvm && !lock_q)
            begin
                // RULE_19: direct programming refused once locked
                nvm_q[g] <= sh_q;
            end
        end
    end

    // Outputs, all straight from flip-flops
    assign CFG_O       = {vol_q[4], vol_q[3], vol_q[2], vol_q[1]};
    assign SDA_O       = sda_o_q;
    assign SDA_OE_O    = oe_q;
    assign CFG_VALID_O = valid_q;
    assign HS_MODE_O   = hs_q;
    assign WP_LOCKED_O = lock_q;

    // Checks on what the engine drives
    a_start_to_addr: assert property (@(posedge CLK_I) disable iff (SRST_I) // RULE_04
        (start_e && !stop_e && st_q != S_LOAD) |=> (st_q == S_ADDR) && (cnt_q == 4'h0) && !oe_q)
        else $error("start did not restart the address phase");

    a_sda_change_low: assert property (@(posedge CLK_I) disable iff (SRST_I) // RULE_05
        ($changed(oe_q) && !$past(start_e) && !$past(stop_e)) |-> !pin_f_q.scl)
        else $error("data line changed while the clock was high");

    a_ack_addr_hold: assert property (@(posedge CLK_I) disable iff (SRST_I) // RULE_06
        (st_q == S_ADDR && cnt_q == `ICS_BIT_END && pin_f_q.scl && addr_hit) |-> oe_q)
        else $error("address acknowledge not held during the ninth clock");

    a_silent_other: assert property (@(posedge CLK_I) disable iff (SRST_I) // RULE_03
        (st_q == S_ADDR && fall_e && cnt_q == `ICS_BIT_ACK && !addr_hit && !start_e
         && !stop_e) |=> !oe_q [*2])
        else $error("acknowledged a foreign address");

    a_stop_release: assert property (@(posedge CLK_I) disable iff (SRST_I) // RULE_08
        (stop_e && st_q != S_LOAD) |=> !oe_q && !hs_q && (st_q == S_IDLE))
        else $error("stop did not release the bus");

    a_hs_enter: assert property (@(posedge CLK_I) disable iff (SRST_I) // RULE_10
        (st_q == S_ADDR && fall_e && cnt_q == `ICS_BIT_ACK && hs_code && !start_e
         && !stop_e) |=> hs_q && !oe_q)
        else $error("master code handled wrongly");

    a_unmapped_zero: assert property (@(posedge CLK_I) disable iff (SRST_I) // RULE_09
        (st_q == S_ADDR && fall_e && cnt_q == `ICS_BIT_END && addr_hit && rw_q
         && !ptr_rw_hit && !ptr_stat && !ptr_ctrl) |=> (tx_q == 8'h00) && oe_q)
        else $error("unmapped read did not return zero");

    a_commit_vol: assert property (@(posedge CLK_I) disable iff (SRST_I) // RULE_14
        (wr_e && ptr_q == `ICS_REG_CFG && !sel_nvm) |=> (vol_q[1] == $past(sh_q)))
        else $error("received byte not committed");

    a_lock_holds: assert property (@(posedge CLK_I) disable iff (SRST_I) // RULE_19
        lock_q |=> lock_q && (nvm_q[1] == $past(nvm_q[1])) && (nvm_q[4] == $past(nvm_q[4])))
        else $error("locked storage changed");

    a_load_first: assert property (@(posedge CLK_I) disable iff (SRST_I) // RULE_17
        (st_q == S_LOAD) |=> valid_q && (vol_q[2] == $past(nvm_q[2])) && (st_q == S_IDLE))
        else $error("registers not loaded from storage");

endmodule : ics_i2c_cfg_slave
`default_nettype wire

// ===== sim/ics_master_model.sv
// Two-wire bus master model that makes the link clock and drives data open drain
`default_nettype none
module ics_master_model
(
    output var  logic SCL_O,
    output var  logic SDA_OE_O,
    input  wire logic SDA_I
);
    timeunit 1ns;
    timeprecision 100ps;

    // Link clock parks high and data is released between frames
    initial
    begin
        SCL_O    = 1'b1;
        SDA_OE_O = 1'b0;
    end

    // One quarter of the 125 ns link period; both lines move together then wait
    task automatic step(input logic s, input logic oe);
        SCL_O    <= s;
        SDA_OE_O <= oe;
        #31.25;
    endtask : step

    task automatic start;
        step(SCL_O, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask : start

    task automatic stop;
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b1, 1'b0);
    endtask : stop

    // data set while clock low, sampled mid high phase
    task automatic bitx(input logic b, output logic r);
        step(1'b0, !b);
        step(1'b1, !b);
        r = SDA_I;
        step(1'b1, !b);
        step(1'b0, !b);
    endtask : bitx

    // eight bits MSB first then the slave's acknowledge
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(d[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask : wbyte

    // read a byte, then acknowledge or refuse it
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(1'b1, d[i]);
        bitx(!ack, r);
    endtask : rbyte
endmodule : ics_master_model
`default_nettype wire

// ===== sim/ics_i2c_cfg_slave_tb_top.sv
// Self-checking bench of the two-wire configuration slave
`default_nettype none
module ics_i2c_cfg_slave_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import ics_pkg::*;

    typedef struct packed
    {
        logic [7:0] p;
        logic [7:0] d;
        logic [7:0] r;
    } ics_row_t;

    logic       clk;
    logic       srst;
    logic [7:0] status;
    logic       scl;
    logic       oe_m;
    wire logic  oe_s;
    wire logic  sda_drv;
    wire logic  hs;
    wire logic  valid;
    wire logic  locked;
    wire ics_cfg_t cfg;
    wire logic  sda;
    int         bad_count;
    int         num_checks;
    int         n;
    logic       a;
    logic [7:0] d;
    ics_row_t   rows [6] = '{'{8'h01, 8'hA5, 8'hA5}, '{8'h02, 8'h3C, 8'h3C},
                             '{8'h03, 8'hC3, 8'hC3}, '{8'h04, 8'h5A, 8'h5A},
                             '{8'h05, 8'h77, 8'h9E}, '{8'h3A, 8'h55, 8'h00}};
    logic [7:0] foreign [3] = '{8'hEC, 8'h00, 8'hF0};

    // Pulled-up wire: low while either party pulls it
    assign sda = !(oe_s | oe_m);

    ics_i2c_cfg_slave ics_i2c_cfg_slave_i
    (
        .CLK_I       (clk),
        .SRST_I      (srst),
        .SCL_I       (scl),
        .SDA_I       (sda),
        .SDA_O       (sda_drv),
        .SDA_OE_O    (oe_s),
        .STATUS_I    (status),
        .CFG_O       (cfg),
        .CFG_VALID_O (valid),
        .HS_MODE_O   (hs),
        .WP_LOCKED_O (locked)
    );

    ics_master_model ics_master_model_i
    (
        .SCL_O    (scl),
        .SDA_OE_O (oe_m),
        .SDA_I    (sda)
    );

    // Core clock, 100 MHz
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    // Single register update, every byte must be acknowledged
    task automatic wr(input logic [7:0] p, input logic [7:0] v);
        logic k;
        ics_master_model_i.start;
        ics_master_model_i.wbyte(8'hEA, k);
        chk("addr ack", k, 1'b1);
        ics_master_model_i.wbyte(p, k);
        chk("ptr ack", k, 1'b1);
        ics_master_model_i.wbyte(v, k);
        chk("data ack", k, 1'b1);
        ics_master_model_i.stop;
    endtask : wr

    // Pointer write, repeated start, one byte read ended by refusal
    task automatic rd(input logic [7:0] p, output logic [7:0] v);
        logic k;
        ics_master_model_i.start;
        ics_master_model_i.wbyte(8'hEA, k);
        ics_master_model_i.wbyte(p, k);
        ics_master_model_i.start;
        ics_master_model_i.wbyte(8'hEB, k);
        chk("read addr ack", k, 1'b1);
        ics_master_model_i.rbyte(1'b0, v);
        ics_master_model_i.stop;
    endtask : rd

    // Hang guard: a run this long has lost the bus
    initial
    begin
        #500000;
        bad_count++;
        $display("timeout");
        conclude;
    end

    // Main sequence
    initial
    begin
        srst   <= 1'b1;
        status <= 8'h9E;
        repeat (20) @(posedge clk);
        chk("cfg in reset", cfg, 32'h0);
        chk("valid in reset", valid, 1'b0);
        srst <= 1'b0;
        for (n = 0; n < 50 && valid !== 1'b1; n++)
            @(posedge clk);
        chk("load valid", valid, 1'b1);
        chk("factory load", cfg, 32'h00000601);
        chk("sda drive", sda_drv, 1'b0);
        if (valid !== 1'b1)
            conclude;
        ics_master_model_i.stop;
        rd(8'hFF, d);
        chk("ctrl reset", d, 8'h00);
        $display("reset test done");
        // Ordinary accesses, one row each
        foreach (rows[i])
        begin
            wr(rows[i].p, rows[i].d);
            rd(rows[i].p, d);
            chk("row read", d, rows[i].r);
        end
        chk("cfg after rows", cfg, 32'h5AC33CA5);
        $display("row test done");
        // Foreign, general call and ten-bit prefix stay unanswered
        foreach (foreign[i])
        begin
            ics_master_model_i.start;
            ics_master_model_i.wbyte(foreign[i], a);
            chk("foreign ack", a, 1'b0);
            ics_master_model_i.stop;
        end
        $display("address test done");
        // Master code, then a write at high speed ended by stop
        ics_master_model_i.start;
        ics_master_model_i.wbyte(8'h09, a);
        chk("code ack", a, 1'b0);
        repeat (6) @(posedge clk);
        chk("hs on", hs, 1'b1);
        wr(8'h02, 8'h11);
        repeat (10) @(posedge clk);
        chk("hs off", hs, 1'b0);
        chk("hs write", cfg.low_th, 8'h11);
        // Byte cut short by a stop writes nothing
        ics_master_model_i.start;
        ics_master_model_i.wbyte(8'hEA, a);
        ics_master_model_i.wbyte(8'h03, a);
        for (n = 0; n < 4; n++)
            ics_master_model_i.bitx(1'b0, a);
        ics_master_model_i.stop;
        chk("abort", cfg.up_th, 8'hC3);
        $display("speed test done");
        // Save with protect, then the stored copy refuses change
        wr(8'hFF, 8'hC0);
        for (n = 0; n < 100 && locked !== 1'b1; n++)
            @(posedge clk);
        chk("locked", locked, 1'b1);
        wr(8'hFF, 8'h41);
        rd(8'h01, d);
        chk("stored cfg", d, 8'hA5);
        wr(8'h01, 8'h33);
        rd(8'h01, d);
        chk("locked cfg", d, 8'hA5);
        rd(8'hFF, d);
        chk("ctrl read", d, 8'h61);
        wr(8'hFF, 8'h00);
        rd(8'h01, d);
        chk("volatile cfg", d, 8'hA5);
        $display("save test done");
        conclude;
    end
endmodule : ics_i2c_cfg_slave_tb_top
`default_nettype wire
